// [hdl/alc_pkg.sv]
// Constants and carrier types for the front-end line control block.
// Assumes a single 125 MHz clock domain.
package alc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESUME_US = 1000;
  localparam int RESUME_CYC = RESUME_US * 1000 / CLK_PERIOD_NS;
  localparam int RING_HOLD_NS = 2000;
  localparam int RING_HOLD_CYC =
    (RING_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int F0_DIV_DEF = 100;
  localparam int SLOT_BITS = 16;
  localparam int CL_BIT = 2;
  localparam int OH_BIT = 3;
  localparam int PWR_MODE_BIT = 4;
  localparam int RING_STAT_BIT = 5;
  localparam int CLK0_BIT = 6;
  localparam int CLK3_BIT = 10;
  localparam logic [3:0] GPIO_DIR_RST = 4'h0;
  localparam logic [1:0] HOOK_ON = 2'h0;
  localparam logic [1:0] HOOK_OFF = 2'h1;
  localparam logic [1:0] HOOK_CID = 2'h2;
  localparam logic [1:0] HOOK_SPECIAL = 2'h3;
  localparam logic [1:0] TX_MUTE = 2'h0;
  localparam logic [2:0] OVC_384 = 3'h1;
  localparam logic [2:0] OVC_128 = 3'h5;
  localparam logic [2:0] OVC_192 = 3'h6;
  localparam logic [2:0] OVC_256 = 3'h7;
  localparam logic [15:0] OVER_320 = 16'h0140;
  localparam logic [15:0] OVER_384 = 16'h0180;
  localparam logic [15:0] OVER_128 = 16'h0080;
  localparam logic [15:0] OVER_192 = 16'h00c0;
  localparam logic [15:0] OVER_256 = 16'h0100;

  typedef enum {PW_ACTIVE, PW_OFF, PW_WAKE, PW_SERIAL, PW_RESUME} alc_pwr_e;

  typedef struct packed {
    logic [2:0] over_code;
    logic m_is_two;
    logic [2:0] q_code;
    logic [7:0] bit_div;
    logic [1:0] tx_gain;
    logic rx_aux;
    logic rx_gain_6db;
    logic [3:0] gpio_mask;
    logic [3:0] gpio_dir;
    logic ring_mask;
    logic [7:0] f0_n;
    logic [15:0] ctrl2;
    logic [15:0] ctrl3;
  } alc_cfg_s;
endpackage : alc_pkg

// [hdl/alc_line_ctrl.sv]
// Digital control of a modem front end: frame timing, power-down,
// general pins, interrupt and isolation pair drive.
// Assumes config arrives on i_clk from the serial port logic; pins async.
`timescale 1ns/100ps

module alc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_reg <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule : alc_sync

module alc_line_ctrl #(
  parameter int RESUME_CYC = alc_pkg::RESUME_CYC,
  parameter int F0_DIV = alc_pkg::F0_DIV_DEF
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire alc_pkg::alc_cfg_s i_cfg,
  input wire logic i_reg2_read,
  input wire logic i_divider_clock_select,
  input wire logic i_master_select,
  input wire logic i_power_down_n,
  input wire logic i_hook_source_select,
  input wire logic i_slot_select_pin,
  input wire logic i_fs,
  input wire logic [3:0] i_aux_pin,
  input wire logic i_line_receive_pos,
  input wire logic i_line_receive_neg,
  output logic o_fs,
  output logic o_fs_oe_n,
  output logic o_slot_active,
  output logic [3:0] o_aux_pin,
  output logic [3:0] o_aux_pin_oe_n,
  output logic o_general_interrupt_out,
  output logic o_isolation_ctrl_a,
  output logic o_isolation_ctrl_b,
  output logic o_ring,
  output logic [15:0] o_status,
  output logic [1:0] o_line_state,
  output logic o_demod_half_rate,
  output logic [1:0] o_tx_gain,
  output logic o_rx_aux_sel,
  output logic o_rx_gain_6db,
  output logic o_core_on,
  output logic o_serial_on,
  output logic o_ring_detect_on
);
  logic [10:0] pin_s;
  logic mcm_s, ms_s, pd_n_s, pd_s, hm_s, ts_s, fs_s, rx_p_s, rx_n_s;
  logic [3:0] gp_s;

  // Power-down pin idles high: sync its inverse so reset reads it high
  alc_sync #(.W(11)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d({i_divider_clock_select, i_master_select, ~i_power_down_n,
      i_hook_source_select, i_slot_select_pin, i_fs, i_aux_pin,
      i_line_receive_pos}),
    .o_q(pin_s)
  );
  assign {mcm_s, ms_s, pd_s, hm_s, ts_s, fs_s, gp_s, rx_p_s} = pin_s;
  assign pd_n_s = ~pd_s;

  alc_sync #(.W(1)) u_sync_n (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d(i_line_receive_neg),
    .o_q(rx_n_s)
  );

  // Frame period selection
  logic [15:0] over_w, q2_w, full_w, period_w;
  assign over_w = (i_cfg.over_code == alc_pkg::OVC_384) ? alc_pkg::OVER_384 :
    (i_cfg.over_code == alc_pkg::OVC_128) ? alc_pkg::OVER_128 :
    (i_cfg.over_code == alc_pkg::OVC_192) ? alc_pkg::OVER_192 :
    (i_cfg.over_code == alc_pkg::OVC_256) ? alc_pkg::OVER_256 :
    alc_pkg::OVER_320;
  // Twice Q, so half-integer settings stay exact
  assign q2_w = i_cfg.q_code[2] ? {12'h0, 1'b1, i_cfg.q_code[1:0], 1'b1} :
    (i_cfg.q_code == 3'h0) ? 16'h0006 :
    {12'h0, 1'b1, i_cfg.q_code[1:0], 1'b0} + 16'h0002;
  assign full_w = 16'((over_w * q2_w) >> (i_cfg.m_is_two ? 0 : 1));
  assign period_w = mcm_s ? full_w : over_w;

  logic [15:0] frame_cnt_reg, frame_cnt_next;
  logic fs_prev_reg;
  logic frame_start_w;
  assign frame_cnt_next = (frame_cnt_reg >= period_w - 16'h0001) ?
    16'h0000 : frame_cnt_reg + 16'h0001;
  // Transfer starts on the falling edge of frame sync as slave, at frame count zero as master
  assign frame_start_w = ms_s ? (frame_cnt_reg == 16'h0000) :
    (fs_prev_reg & ~fs_s);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      frame_cnt_reg <= 16'h0000;
      fs_prev_reg <= 1'b0;
      o_fs <= 1'b0;
      o_fs_oe_n <= 1'b1;
    end
    else
    begin
      frame_cnt_reg <= frame_cnt_next;
      fs_prev_reg <= fs_s;
      o_fs <= ms_s & (frame_cnt_next == 16'h0000);
      o_fs_oe_n <= ~ms_s;
    end
  end

  // Bit clock enable and slot window
  logic [7:0] bit_div_reg;
  logic [5:0] bit_idx_reg;
  logic bit_en_w, in_slot_w;
  assign bit_en_w = (bit_div_reg >= i_cfg.bit_div - 8'h01);
  assign in_slot_w = (bit_idx_reg < 6'(2 * alc_pkg::SLOT_BITS)) &&
    ((bit_idx_reg >= 6'(alc_pkg::SLOT_BITS)) == ts_s);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      bit_div_reg <= 8'h00;
      bit_idx_reg <= 6'h3f;
      o_slot_active <= 1'b0;
    end
    else
    begin
      bit_div_reg <= (bit_en_w || frame_start_w) ? 8'h00 :
        bit_div_reg + 8'h01;
      if (frame_start_w)
        bit_idx_reg <= 6'h00;
      else if (bit_en_w && bit_idx_reg != 6'h3f)
        bit_idx_reg <= bit_idx_reg + 6'h01;
      o_slot_active <= in_slot_w & o_serial_on;
    end
  end

  // Carrier clock, its half rate and its N divide
  logic [7:0] car_cnt_reg;
  logic [7:0] n_cnt_reg;
  logic car_reg, half_reg, fon_w, car_rise_w;
  assign car_rise_w = (car_cnt_reg == 8'(F0_DIV / 2 - 1)) & ~car_reg;
  assign fon_w = (i_cfg.f0_n <= 8'h01) ? car_reg :
    (n_cnt_reg < (i_cfg.f0_n >> 1));

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      car_cnt_reg <= 8'h00;
      car_reg <= 1'b0;
      half_reg <= 1'b0;
      n_cnt_reg <= 8'h00;
    end
    else
    begin
      if (car_cnt_reg == 8'(F0_DIV / 2 - 1))
      begin
        car_cnt_reg <= 8'h00;
        car_reg <= ~car_reg;
      end
      else
        car_cnt_reg <= car_cnt_reg + 8'h01;
      if (car_rise_w)
      begin
        half_reg <= ~half_reg;
        n_cnt_reg <= (n_cnt_reg >= i_cfg.f0_n - 8'h01) ? 8'h00 :
          n_cnt_reg + 8'h01;
      end
    end
  end

  // Line state source
  logic [1:0] hook_w;
  assign hook_w = hm_s ? {gp_s[1], gp_s[2]} :
    {i_cfg.ctrl3[alc_pkg::CL_BIT], i_cfg.ctrl3[alc_pkg::OH_BIT]};

  // Power sequencing
  alc_pkg::alc_pwr_e pwr_reg, pwr_next;
  logic [31:0] res_cnt_reg;
  logic wake_mode_w, gp_evt_w, ring_evt_w, irq_evt_w;
  assign wake_mode_w = i_cfg.ctrl3[alc_pkg::PWR_MODE_BIT];

  always_comb
  begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      alc_pkg::PW_ACTIVE:
        if (!pd_n_s)
          pwr_next = wake_mode_w ? alc_pkg::PW_WAKE :
            alc_pkg::PW_OFF;
      alc_pkg::PW_OFF:
        if (pd_n_s)
          pwr_next = alc_pkg::PW_RESUME;
      alc_pkg::PW_WAKE:
        if (pd_n_s)
          pwr_next = alc_pkg::PW_RESUME;
        else if (irq_evt_w)
          pwr_next = alc_pkg::PW_SERIAL;
      alc_pkg::PW_SERIAL:
        if (pd_n_s)
          pwr_next = alc_pkg::PW_RESUME;
        else if (i_reg2_read)
          pwr_next = alc_pkg::PW_WAKE;
      alc_pkg::PW_RESUME:
        if (!pd_n_s)
          pwr_next = wake_mode_w ? alc_pkg::PW_WAKE : alc_pkg::PW_OFF;
        else if (res_cnt_reg >= 32'(RESUME_CYC - 1))
          pwr_next = alc_pkg::PW_ACTIVE;
      default:
        pwr_next = alc_pkg::PW_ACTIVE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pwr_reg <= alc_pkg::PW_ACTIVE;
      res_cnt_reg <= 32'h0;
      o_core_on <= 1'b1;
      o_serial_on <= 1'b1;
      o_ring_detect_on <= 1'b1;
    end
    else
    begin
      pwr_reg <= pwr_next;
      res_cnt_reg <= (pwr_reg == alc_pkg::PW_RESUME) ?
        res_cnt_reg + 32'h1 : 32'h0;
      o_core_on <= pwr_next == alc_pkg::PW_ACTIVE;
      o_serial_on <= pwr_next == alc_pkg::PW_ACTIVE ||
        pwr_next == alc_pkg::PW_SERIAL;
      o_ring_detect_on <= pwr_next != alc_pkg::PW_OFF;
    end
  end

  // Ring burst envelope
  logic rx_diff_reg, env_w;
  logic [15:0] ring_hold_reg;
  assign env_w = ring_hold_reg != 16'h0;

  // General pin direction, value and events
  logic [3:0] dir_w, val_w, gp_prev_reg;
  assign dir_w = i_cfg.gpio_dir & (hm_s ? 4'h9 : 4'hf);
  assign val_w = {i_cfg.ctrl2[alc_pkg::CLK3_BIT] ? car_reg :
    i_cfg.ctrl2[3], i_cfg.ctrl2[2:1],
    i_cfg.ctrl2[alc_pkg::CLK0_BIT] ? fon_w : i_cfg.ctrl2[0]};
  assign gp_evt_w = |((gp_s ^ gp_prev_reg) & ~dir_w &
    ~i_cfg.gpio_mask);
  assign ring_evt_w = (o_ring != env_w) & ~i_cfg.ring_mask;
  assign irq_evt_w = (gp_evt_w | ring_evt_w) &
    (pwr_reg != alc_pkg::PW_OFF);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rx_diff_reg <= 1'b0;
      ring_hold_reg <= 16'h0;
      o_ring <= 1'b0;
      gp_prev_reg <= 4'h0;
      o_aux_pin <= 4'h0;
      o_aux_pin_oe_n <= ~alc_pkg::GPIO_DIR_RST;
      o_general_interrupt_out <= 1'b0;
      o_status <= 16'h0;
    end
    else
    begin
      rx_diff_reg <= rx_p_s & ~rx_n_s;
      if ((rx_diff_reg != (rx_p_s & ~rx_n_s)) && o_ring_detect_on &&
        o_line_state == alc_pkg::HOOK_ON)
        ring_hold_reg <= 16'(alc_pkg::RING_HOLD_CYC);
      else if (env_w)
        ring_hold_reg <= ring_hold_reg - 16'h1;
      o_ring <= env_w;
      gp_prev_reg <= gp_s;
      o_aux_pin <= val_w & dir_w;
      o_aux_pin_oe_n <= ~dir_w;
      if (irq_evt_w)
        o_general_interrupt_out <= 1'b1;
      else if (i_reg2_read)
        o_general_interrupt_out <= 1'b0;
      o_status <= 16'h0;
      o_status[alc_pkg::RING_STAT_BIT] <= env_w;
      o_status[3:0] <= gp_s;
    end
  end

  // Isolation pair and analog path settings
  logic iso_a_w, iso_b_w;
  always_comb
  begin
    iso_a_w = 1'b1;
    iso_b_w = 1'b1;
    if (o_core_on)
      case (hook_w)
        alc_pkg::HOOK_OFF, alc_pkg::HOOK_SPECIAL:
        begin
          iso_a_w = car_reg;
          iso_b_w = ~car_reg;
        end
        alc_pkg::HOOK_CID:
          iso_a_w = car_reg;
        default:
          iso_a_w = 1'b1;
      endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_isolation_ctrl_a <= 1'b1;
      o_isolation_ctrl_b <= 1'b1;
      o_line_state <= alc_pkg::HOOK_ON;
      o_demod_half_rate <= 1'b0;
      o_tx_gain <= alc_pkg::TX_MUTE;
      o_rx_aux_sel <= 1'b0;
      o_rx_gain_6db <= 1'b0;
    end
    else
    begin
      o_isolation_ctrl_a <= iso_a_w;
      o_isolation_ctrl_b <= iso_b_w;
      o_line_state <= hook_w;
      o_demod_half_rate <= hook_w == alc_pkg::HOOK_CID;
      o_tx_gain <= o_core_on ? i_cfg.tx_gain : alc_pkg::TX_MUTE;
      o_rx_aux_sel <= i_cfg.rx_aux;
      o_rx_gain_6db <= i_cfg.rx_gain_6db;
    end
  end
endmodule : alc_line_ctrl

// [sim/alc_line_ctrl_props.sv]
// Concurrent checks on the line control block, bound to its ports.
// Assumes one clock domain with reset asynchronous and active high.
`timescale 1ns/100ps

module alc_line_ctrl_props (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire alc_pkg::alc_cfg_s i_cfg,
  input wire logic i_reg2_read,
  input wire logic i_power_down_n,
  input wire logic i_hook_source_select,
  input wire logic [3:0] i_aux_pin,
  input wire logic [3:0] o_aux_pin_oe_n,
  input wire logic o_general_interrupt_out,
  input wire logic o_isolation_ctrl_a,
  input wire logic o_isolation_ctrl_b,
  input wire logic o_ring,
  input wire logic [1:0] o_line_state,
  input wire logic o_demod_half_rate,
  input wire logic o_core_on,
  input wire logic o_serial_on,
  input wire logic o_ring_detect_on
);
  wire [3:0] live_w = ~i_cfg.gpio_mask & ~i_cfg.gpio_dir;
  wire [1:0] reg_state_w = {i_cfg.ctrl3[alc_pkg::CL_BIT],
    i_cfg.ctrl3[alc_pkg::OH_BIT]};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_reset_inputs: assert property (disable iff (1'b0)
    i_reset |-> o_aux_pin_oe_n == 4'hf) else $error("pins not inputs");
  a_onhook_idle: assert property (
    (o_line_state == alc_pkg::HOOK_ON)[*3] |->
    o_isolation_ctrl_a && o_isolation_ctrl_b) else $error("on-hook drive");
  a_offhook_phase: assert property (
    (o_line_state == alc_pkg::HOOK_OFF && o_core_on)[*3] |->
    o_isolation_ctrl_a != o_isolation_ctrl_b) else $error("off-hook drive");
  a_cid_drive: assert property (
    (o_line_state == alc_pkg::HOOK_CID && o_core_on)[*3] |->
    o_isolation_ctrl_b && o_demod_half_rate) else $error("cid drive");
  a_reg_state: assert property (
    (!i_hook_source_select && $stable(i_cfg.ctrl3) && o_core_on)[*5] |->
    o_line_state == reg_state_w) else $error("line state");
  a_full_off: assert property (
    (!i_power_down_n && !i_cfg.ctrl3[alc_pkg::PWR_MODE_BIT])[*5] |->
    !o_core_on && !o_serial_on && !o_ring_detect_on) else $error("not off");
  a_wake_keep: assert property (
    (!i_power_down_n && i_cfg.ctrl3[alc_pkg::PWR_MODE_BIT])[*5] |->
    !o_core_on && o_ring_detect_on) else $error("wake mode");
  a_pin_event: assert property (
    $changed(i_aux_pin[0]) && live_w[0] && o_ring_detect_on |->
    ##[1:5] o_general_interrupt_out) else $error("missed pin event");
  a_read_clear: assert property (
    ($stable(i_aux_pin) && $stable(o_ring))[*4] ##0 i_reg2_read |=>
    !o_general_interrupt_out) else $error("interrupt kept");
  a_wake_serial: assert property (
    $rose(o_general_interrupt_out) && !o_core_on && !i_power_down_n |->
    o_serial_on) else $error("serial not woken");

  c_cid: cover property (o_line_state == alc_pkg::HOOK_CID);
  c_wake: cover property (o_serial_on && !o_core_on);
  c_clear: cover property ($fell(o_general_interrupt_out));
endmodule : alc_line_ctrl_props

bind alc_line_ctrl alc_line_ctrl_props u_props (.i_clk(i_clk),
  .i_reset(i_reset), .i_cfg(i_cfg), .i_reg2_read(i_reg2_read),
  .i_power_down_n(i_power_down_n),
  .i_hook_source_select(i_hook_source_select), .i_aux_pin(i_aux_pin),
  .o_aux_pin_oe_n(o_aux_pin_oe_n),
  .o_general_interrupt_out(o_general_interrupt_out),
  .o_isolation_ctrl_a(o_isolation_ctrl_a),
  .o_isolation_ctrl_b(o_isolation_ctrl_b), .o_ring(o_ring),
  .o_line_state(o_line_state), .o_demod_half_rate(o_demod_half_rate),
  .o_core_on(o_core_on), .o_serial_on(o_serial_on),
  .o_ring_detect_on(o_ring_detect_on));

// [sim/alc_far_model.sv]
// Line-side companion model: ring burst on the receive pair.
// Assumes the bench raises i_ring while a ring is to be sent.
`timescale 1ns/100ps

module alc_far_model (
  input wire logic i_clk,
  input wire logic i_ring,
  output logic o_pos,
  output logic o_neg
);
  logic [5:0] cnt_reg = 6'h00;
  logic ph_reg = 1'b0;

  always @(posedge i_clk)
  begin
    cnt_reg <= cnt_reg + 6'h01;
    if (cnt_reg == 6'h3f)
      ph_reg <= ~ph_reg;
  end

  // Burst in opposite phase; idle pair equal but never still
  assign o_pos = i_ring ? ph_reg : cnt_reg[0];
  assign o_neg = i_ring ? ~ph_reg : cnt_reg[0];
endmodule : alc_far_model

// [sim/alc_line_ctrl_tb.sv]
// Bench for the line control block: hook, ring, pins, frame, power.
// Assumes the far-side model and the bound checker are compiled.
`timescale 1ns/100ps

module alc_line_ctrl_tb;
  localparam int RCYC = 20;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic rd = 1'b0;
  logic divider_clock_select = 1'b0;
  logic ms = 1'b0;
  logic pd_n = 1'b1;
  logic hs = 1'b0;
  logic ts = 1'b0;
  logic fs_drv = 1'b1;
  logic ring = 1'b0;
  logic [3:0] pin_drv = 4'h0;
  alc_pkg::alc_cfg_s cfg = '0;
  logic pos, neg, fs_o, fs_oe_n, irq, iso_a, iso_b;
  logic rng, half, core, ser, rdet, slot, rxa, rxg;
  logic [3:0] ap, ap_oe_n;
  logic [15:0] st;
  logic [1:0] ls, txg;
  wire [3:0] pin_w = (ap_oe_n & pin_drv) | (~ap_oe_n & ap);
  wire fs_w = fs_oe_n ? fs_drv : fs_o;
  int fails = 0;
  int checks_done = 0;

  always #4 clk = ~clk;

  alc_far_model far (.i_clk(clk), .i_ring(ring), .o_pos(pos), .o_neg(neg));
  alc_line_ctrl #(.RESUME_CYC(RCYC), .F0_DIV(10)) dut (
    .i_clk(clk), .i_reset(rst), .i_cfg(cfg), .i_reg2_read(rd),
    .i_divider_clock_select(divider_clock_select), .i_master_select(ms),
    .i_power_down_n(pd_n), .i_hook_source_select(hs),
    .i_slot_select_pin(ts), .i_fs(fs_w), .i_aux_pin(pin_w),
    .i_line_receive_pos(pos), .i_line_receive_neg(neg),
    .o_fs(fs_o), .o_fs_oe_n(fs_oe_n), .o_slot_active(slot),
    .o_aux_pin(ap), .o_aux_pin_oe_n(ap_oe_n),
    .o_general_interrupt_out(irq), .o_isolation_ctrl_a(iso_a),
    .o_isolation_ctrl_b(iso_b), .o_ring(rng), .o_status(st),
    .o_line_state(ls), .o_demod_half_rate(half), .o_tx_gain(txg),
    .o_rx_aux_sel(rxa), .o_rx_gain_6db(rxg), .o_core_on(core),
    .o_serial_on(ser), .o_ring_detect_on(rdet));

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task read2;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
  endtask : read2

  task fs_per(output int n);
    for (int i = 0; i < 2000 && fs_o !== 1'b1; i++)
      step(1);
    step(1);
    n = 1;
    while (fs_o !== 1'b1 && n < 2000)
    begin
      step(1);
      n++;
    end
  endtask : fs_per

  task fs_chk(input logic [2:0] q, input logic m, input logic [15:0] e);
    int n;
    cfg.q_code = q;
    cfg.m_is_two = m;
    fs_per(n);
    fs_per(n);
    chk(16'(n), e);
  endtask : fs_chk

  task slot_cnt(output int c);
    c = 0;
    step(1);
    for (int i = 0; i < alc_pkg::SLOT_BITS * 4; i++)
    begin
      step(1);
      c += int'(slot);
    end
  endtask : slot_cnt

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task t_hook;
    logic [1:0] s;
    for (int i = 0; i < 8; i++)
    begin
      s = i[1:0];
      hs = i[2];
      cfg.ctrl3[alc_pkg::CL_BIT] = s[1];
      cfg.ctrl3[alc_pkg::OH_BIT] = s[0];
      pin_drv[2:1] = {s[0], s[1]};
      step(8);
      chk(16'(ls), 16'(s));
      case (s)
        2'h0: chk(16'({iso_a, iso_b, half}), 16'h6);
        2'h2: chk(16'({iso_b, half}), 16'h3);
        default: chk(16'(iso_a ^ iso_b), 16'h1);
      endcase
    end
    $display("hook test over");
  endtask : t_hook

  task t_ring;
    hs = 1'b0;
    cfg.ctrl3 = 16'h0000;
    cfg.ring_mask = 1'b0;
    step(8);
    read2;
    chk(16'(irq), 16'h0);
    ring = 1'b1;
    step(200);
    chk(16'({rng, st[alc_pkg::RING_STAT_BIT], irq}), 16'h7);
    read2;
    chk(16'(irq), 16'h0);
    ring = 1'b0;
    step(300);
    chk(16'({rng, st[alc_pkg::RING_STAT_BIT], irq}), 16'h1);
    read2;
    cfg.ring_mask = 1'b1;
    $display("ring test over");
  endtask : t_ring

  task t_gpio;
    logic [3:0] p;
    int c0;
    int c3;
    cfg.gpio_mask = 4'he;
    step(6);
    read2;
    pin_drv[0] = ~pin_drv[0];
    step(6);
    chk(16'(irq), 16'h1);
    chk(16'(st[0]), 16'(pin_drv[0]));
    read2;
    chk(16'(irq), 16'h0);
    cfg.gpio_mask = 4'hf;
    pin_drv[0] = ~pin_drv[0];
    step(6);
    chk(16'(irq), 16'h0);
    cfg.gpio_dir = 4'h9;
    cfg.ctrl2 = 16'h0440;
    step(10);
    chk(16'(ap_oe_n), 16'h6);
    for (int k = 0; k < 2; k++)
    begin
      cfg.f0_n = k ? 8'h04 : 8'h01;
      step(60);
      c0 = 0;
      c3 = 0;
      for (int i = 0; i < 100; i++)
      begin
        p = ap;
        step(1);
        c0 += int'(p[0] ^ ap[0]);
        c3 += int'(p[3] ^ ap[3]);
      end
      chk(16'(c0), k ? 16'h0005 : 16'h0014);
      chk(16'(c3), 16'h14);
    end
    cfg.gpio_dir = 4'h0;
    $display("pin test over");
  endtask : t_gpio

  task t_frame;
    int n;
    ms = 1'b1;
    cfg.over_code = alc_pkg::OVC_128;
    step(8);
    chk(16'(fs_oe_n), 16'h0);
    fs_per(n);
    fs_per(n);
    chk(16'(n), alc_pkg::OVER_128);
    slot_cnt(n);
    chk(16'(n), 16'(alc_pkg::SLOT_BITS * 4));
    ts = 1'b1;
    step(4);
    fs_per(n);
    slot_cnt(n);
    chk(16'(n), 16'h0000);
    ts = 1'b0;
    divider_clock_select = 1'b1;
    fs_per(n);
    fs_per(n);
    chk(16'(n), 16'h0180);
    fs_chk(3'h2, 1'b0, 16'h0380);
    fs_chk(3'h4, 1'b1, 16'h0480);
    fs_chk(3'h1, 1'b1, 16'h0600);
    ms = 1'b0;
    step(8);
    chk(16'(fs_oe_n), 16'h1);
    fs_drv = 1'b0;
    step(2);
    slot_cnt(n);
    chk(16'(n), 16'(alc_pkg::SLOT_BITS * 4));
    fs_drv = 1'b1;
    $display("frame test over");
  endtask : t_frame

  task t_path;
    for (int i = 0; i < 4; i++)
    begin
      cfg.tx_gain = i[1:0];
      cfg.rx_aux = i[0];
      cfg.rx_gain_6db = i[1];
      step(2);
      chk(16'({txg, rxa, rxg}), 16'({i[1:0], i[0], i[1]}));
    end
    $display("path test over");
  endtask : t_path

  task t_power;
    int n;
    cfg.ctrl3 = 16'h0010;
    pd_n = 1'b0;
    step(8);
    pin_drv[0] = ~pin_drv[0];
    step(8);
    chk(16'({core, ser, rdet}), 16'h1);
    cfg.gpio_mask = 4'he;
    step(4);
    read2;
    pin_drv[0] = ~pin_drv[0];
    step(6);
    chk(16'({irq, ser}), 16'h3);
    read2;
    chk(16'({irq, ser}), 16'h0);
    pd_n = 1'b1;
    n = 0;
    while (core !== 1'b1 && n < 100)
    begin
      step(1);
      n++;
    end
    chk(16'(n >= RCYC && n <= RCYC + 5), 16'h1);
    cfg.ctrl3 = 16'h0000;
    pd_n = 1'b0;
    step(8);
    chk(16'({core, ser, rdet}), 16'h0);
    chk(16'(txg), 16'(alc_pkg::TX_MUTE));
    pd_n = 1'b1;
    step(RCYC + 8);
    chk(16'(core), 16'h1);
    $display("power test over");
  endtask : t_power

  initial
  begin
    rst = 1'b1;
    cfg.gpio_mask = 4'hf;
    cfg.ring_mask = 1'b1;
    cfg.bit_div = 8'h04;
    step(8);
    rst = 1'b0;
    step(4);
    chk(16'(ap_oe_n), 16'hf);
    chk(16'({iso_a, iso_b}), 16'h3);
    chk(16'({core, ser, rdet}), 16'h7);
    t_hook;
    t_ring;
    t_gpio;
    t_frame;
    t_path;
    t_power;
    test_done;
  end

  initial
  begin
    #400000;
    fails++;
    test_done;
  end
endmodule : alc_line_ctrl_tb
